// [core/cct_defs.svh]
// Purpose: offsets, field positions, reset values and counts for the capture/compare timer
// Assumes: word registers on a plain strobe port, 16-bit data in the low bits
// Notes:   included by the filter and timer modules
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH
`define CCT_OFF_COUNT     4'h0
`define CCT_OFF_CAPA      4'h1
`define CCT_OFF_CMPB      4'h2
`define CCT_OFF_CTRLA     4'h3
`define CCT_OFF_CTRLB     4'h4
`define CCT_OFF_STATUS    4'h5
`define CCT_OFF_MASK      4'h6
`define CCT_CTRLA_EN      0
`define CCT_CTRLA_SRC_LO  1
`define CCT_CTRLA_EDGE_LO 3
`define CCT_CTRLA_TRIG    7
`define CCT_CTRLB_FILT_LO 0
`define CCT_CTRLB_MODE    3
`define CCT_RST_CTRL      8'h00
`define CCT_RST_WORD      16'h0000
`define CCT_ST_CAP        0
`define CCT_ST_OVF        1
`define CCT_ST_CMPA       2
`define CCT_ST_CMPB       3
`define CCT_DIV8          8
`define CCT_DIV32         32
`define CCT_SLOW_DIV      128
`define CCT_FILT_SAMPLES  3
`endif

// [core/cct_pkg.sv]
// Purpose: types shared by the capture/compare timer files
// Assumes: nothing from cct_defs.svh; the enum values are written out here
// Notes:   none
package cct_pkg;
  typedef enum logic [1:0] {
    CCT_SRC_F1   = 2'h0,
    CCT_SRC_F8   = 2'h1,
    CCT_SRC_F32  = 2'h2,
    CCT_SRC_FAST = 2'h3
  } cct_src_t;
  typedef struct packed {
    logic       count_enable_bit;
    cct_src_t   src;
    logic [1:0] edge_sel;
    logic       trigger_source_select;
    logic [1:0] filter_clock_select;
    logic       capture_compare_mode_select;
  } cct_cfg_t;
  typedef enum logic [2:0] {
    CCT_IDLE    = 3'b001,
    CCT_CAPTURE = 3'b010,
    CCT_COMPARE = 3'b100
  } cct_state_t;
endpackage

// [core/cct_filter.sv]
// Purpose: three-sample digital noise filter for the capture input
// Assumes: input already synchronous to the clock, sample_i a one-cycle tick
// Notes:   output changes only after three equal samples in a row
`timescale 1ns/1ps
`include "cct_defs.svh"
module cct_filter
  import cct_pkg::*;
(
  // clock, reset and enable
  input  wire logic CORE_CLK_I,
  input  wire logic RST_I,
  input  wire logic ce_i,
  // samples
  input  wire logic sample_i,
  input  wire logic din_i,
  output logic      dout_o
);
  logic [1:0] hist;
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      hist   <= 2'h0;
      dout_o <= 1'b0;
    end else if (ce_i && sample_i) begin
      hist <= {hist[0], din_i};
      if (hist[1] == din_i && hist[0] == din_i) begin
        dout_o <= din_i; // RULE15
      end
    end
  end
endmodule

// [core/cct_timer.sv]
// Purpose: 16-bit capture/compare timer with register port and interrupts
// Assumes: all inputs synchronous to CORE_CLK_I; fast oscillator tick arrives as a pulse
// Notes:   compare waveform output and buffered compare updates are not built
// What this block does
// [RULE1] count source is clock divided by 1, 8, 32, or fast oscillator tick
// [RULE2] capture mode counts each tick and latches count on active trigger edge
// [RULE3] counter clears to zero whenever counting is stopped
// [RULE4] counting starts when enable bit set, stops when cleared
// [RULE5] each accepted capture edge raises the pin interrupt
// [RULE6] counter overflow raises the overflow interrupt
// [RULE7] in capture mode writes to counter and capture register are ignored
// [RULE8] software reads counter and capture register as whole 16-bit words
// [RULE9] counter read gives running count, capture read gives latched count
// [RULE10] two-bit field picks the active edge polarity of the input
// [RULE11] input passes a noise filter with selectable sampling rate
// [RULE12] trigger comes from filtered pin or slow oscillator divided by 128
// [RULE13] capture interrupt lags edge by filter delay plus one source period
// [RULE14] compare mode interrupts when count equals either compare register
// [RULE15] filter accepts a level after three equal consecutive samples
// [RULE16] mode bit zero selects capture, one selects compare
// [RULE17] counter, capture and compare registers are sixteen bits
// [RULE18] counter wraps from all ones to zero and keeps counting
// [RULE19] edges found by comparing filtered level with previous sample
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "cct_defs.svh"
module cct_timer
  import cct_pkg::*;
(
  // clock, reset, enable
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  // register port
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  // pins and oscillator ticks
  input  wire logic        CAPTURE_INPUT_PIN_I,
  input  wire logic        FAST_INTERNAL_OSC_I,
  input  wire logic        SLOW_OSC_I,
  // interrupts
  output logic             EXTERNAL_PIN_IRQ_O,
  output logic             IRQ_O
);
  cct_cfg_t   cfg;
  cct_state_t state;
  logic [15:0] count_register;
  logic [15:0] capture_compare_reg_a;
  logic [15:0] compare_reg_b;
  logic [3:0]  status;
  logic [3:0]  mask;
  logic [4:0]  pre_cnt;
  logic [6:0]  slow_cnt;
  logic        slow_osc_div_tick;
  logic        filt_tick;
  logic        filt_level;
  logic        trig_prev;
  logic        trig_level;
  logic        trig_edge;
  logic        src_tick;
  logic        cap_pend;
  logic [3:0]  ev;
  logic [3:0]  clr;

  function automatic logic hit(input logic [4:0] cnt, input logic [1:0] sel);
    case (sel)
      2'h0:    hit = 1'b1;
      2'h1:    hit = (cnt[2:0] == 3'h7);
      2'h2:    hit = (cnt == 5'h1f);
      default: hit = 1'b0;
    endcase
  endfunction

  // shared prescaler; free running so a stopped count leaves no phase skew issue
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      pre_cnt <= 5'h0;
    end else if (CE_I) begin
      pre_cnt <= pre_cnt + 5'h1;
    end
  end

  always_comb begin
    case (cfg.src)
      CCT_SRC_F1:   src_tick = 1'b1; // RULE1
      CCT_SRC_F8:   src_tick = hit(pre_cnt, 2'h1);
      CCT_SRC_F32:  src_tick = hit(pre_cnt, 2'h2);
      CCT_SRC_FAST: src_tick = FAST_INTERNAL_OSC_I;
      default:      src_tick = 1'b0;
    endcase
  end

  // filter sample clock: f1, f8, f32, or count source
  always_comb begin
    if (cfg.filter_clock_select == 2'h3) begin
      filt_tick = src_tick; // RULE11
    end else begin
      filt_tick = hit(pre_cnt, cfg.filter_clock_select);
    end
  end

  // slow oscillator divided by 128: top bit of a 7-bit tick counter, even duty
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      slow_cnt <= 7'h0;
    end else if (CE_I && SLOW_OSC_I) begin
      slow_cnt <= slow_cnt + 7'h1;
    end
  end
  assign slow_osc_div_tick = slow_cnt[6]; // RULE12

  cct_filter u_filter (
    .CORE_CLK_I (CORE_CLK_I),
    .RST_I      (RST_I),
    .ce_i       (CE_I),
    .sample_i   (filt_tick),
    .din_i      (CAPTURE_INPUT_PIN_I),
    .dout_o     (filt_level)
  );

  assign trig_level = cfg.trigger_source_select ? slow_osc_div_tick : filt_level; // RULE12

  // edge select: 0 rising, 1 falling, 2 both, 3 none
  always_comb begin
    case (cfg.edge_sel)
      2'h0:    trig_edge = trig_level & ~trig_prev; // RULE10
      2'h1:    trig_edge = ~trig_level & trig_prev;
      2'h2:    trig_edge = trig_level ^ trig_prev;
      default: trig_edge = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      trig_prev <= 1'b0;
    end else if (CE_I) begin
      trig_prev <= trig_level; // RULE19
    end
  end

  // state follows enable and mode
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state <= CCT_IDLE;
    end else if (CE_I) begin
      case (1'b1)
        !cfg.count_enable_bit:           state <= CCT_IDLE; // RULE4
        cfg.capture_compare_mode_select: state <= CCT_COMPARE; // RULE16
        default:                         state <= CCT_CAPTURE;
      endcase
    end
  end

  // capture is held until the next count tick, so irq lags by at most one period plus one clock cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      cap_pend <= 1'b0;
    end else if (CE_I) begin
      if (state != CCT_CAPTURE) begin
        cap_pend <= 1'b0;
      end else if (trig_edge) begin
        cap_pend <= 1'b1;
      end else if (src_tick) begin
        cap_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      count_register <= `CCT_RST_WORD;
    end else if (CE_I) begin
      if (state == CCT_IDLE || !cfg.count_enable_bit) begin
        count_register <= `CCT_RST_WORD; // RULE3
      end else if (src_tick) begin
        count_register <= count_register + 16'h0001; // RULE2 RULE18
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      capture_compare_reg_a <= `CCT_RST_WORD;
      compare_reg_b         <= `CCT_RST_WORD;
    end else if (CE_I) begin
      if (state == CCT_CAPTURE && cap_pend && src_tick) begin
        capture_compare_reg_a <= count_register; // RULE2
      end else if (WR_I && cfg.capture_compare_mode_select) begin
        // capture mode ignores these writes
        if (ADDR_I == `CCT_OFF_CAPA) begin
          capture_compare_reg_a <= WDATA_I; // RULE7
        end
        if (ADDR_I == `CCT_OFF_CMPB) begin
          compare_reg_b <= WDATA_I;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      cfg <= cct_cfg_t'(9'(`CCT_RST_CTRL));
    end else if (CE_I && WR_I) begin
      if (ADDR_I == `CCT_OFF_CTRLA) begin
        cfg.count_enable_bit      <= WDATA_I[`CCT_CTRLA_EN]; // RULE4
        cfg.src                   <= cct_src_t'(WDATA_I[`CCT_CTRLA_SRC_LO +: 2]);
        cfg.edge_sel              <= WDATA_I[`CCT_CTRLA_EDGE_LO +: 2];
        cfg.trigger_source_select <= WDATA_I[`CCT_CTRLA_TRIG];
      end
      if (ADDR_I == `CCT_OFF_CTRLB) begin
        cfg.filter_clock_select         <= WDATA_I[`CCT_CTRLB_FILT_LO +: 2];
        cfg.capture_compare_mode_select <= WDATA_I[`CCT_CTRLB_MODE];
      end
    end
  end

  // events; set wins over write-one-to-clear
  always_comb begin
    ev = 4'h0;
    ev[`CCT_ST_CAP]  = (state == CCT_CAPTURE) && cap_pend && src_tick; // RULE5 RULE13
    ev[`CCT_ST_OVF]  = (state != CCT_IDLE) && src_tick
                       && (count_register == 16'hffff); // RULE6
    ev[`CCT_ST_CMPA] = (state == CCT_COMPARE)
                       && (count_register == capture_compare_reg_a); // RULE14
    ev[`CCT_ST_CMPB] = (state == CCT_COMPARE) && (count_register == compare_reg_b);
    clr = (WR_I && ADDR_I == `CCT_OFF_STATUS) ? WDATA_I[3:0] : 4'h0;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      status <= 4'h0;
      mask   <= 4'h0;
    end else if (CE_I) begin
      status <= (status & ~clr) | ev;
      if (WR_I && ADDR_I == `CCT_OFF_MASK) begin
        mask <= WDATA_I[3:0];
      end
    end
  end

  assign EXTERNAL_PIN_IRQ_O = status[`CCT_ST_CAP] & mask[`CCT_ST_CAP]; // RULE5
  assign IRQ_O              = |(status & mask);

  // whole-word reads only, so the 16-bit value is coherent
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      RDATA_O <= 16'h0000;
    end else if (CE_I) begin
      RDATA_O <= 16'h0000;
      if (RD_I) begin
        case (ADDR_I)
          `CCT_OFF_COUNT:  RDATA_O <= count_register; // RULE9 RULE8 RULE17
          `CCT_OFF_CAPA:   RDATA_O <= capture_compare_reg_a; // RULE9
          `CCT_OFF_CMPB:   RDATA_O <= compare_reg_b;
          `CCT_OFF_CTRLA:  RDATA_O <= {8'h00, cfg.trigger_source_select, 2'h0,
                                       cfg.edge_sel, cfg.src, cfg.count_enable_bit};
          `CCT_OFF_CTRLB:  RDATA_O <= {12'h000, cfg.capture_compare_mode_select, 1'b0,
                                       cfg.filter_clock_select};
          `CCT_OFF_STATUS: RDATA_O <= {12'h000, status};
          `CCT_OFF_MASK:   RDATA_O <= {12'h000, mask};
          default:         RDATA_O <= 16'h0000;
        endcase
      end
    end
  end

  a_stop_clears: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE3
    CE_I && !cfg.count_enable_bit |=> count_register == 16'h0000)
    else $error("counter not cleared while stopped");
  a_count_step: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE2
    CE_I && state != CCT_IDLE && cfg.count_enable_bit && src_tick
    |=> count_register == $past(count_register) + 16'h0001)
    else $error("counter did not step on tick");
  a_hold_notick: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE1
    CE_I && cfg.count_enable_bit && !src_tick |=> $stable(count_register))
    else $error("counter moved without tick");
  a_capture_val: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE2
    CE_I && ev[`CCT_ST_CAP] |=> capture_compare_reg_a == $past(count_register))
    else $error("capture value wrong");
  a_cap_ignore: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE7
    CE_I && state == CCT_CAPTURE && !cfg.capture_compare_mode_select
    && !ev[`CCT_ST_CAP] |=> $stable(capture_compare_reg_a))
    else $error("capture register changed by write");
  a_ovf_flag: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE6
    CE_I && ev[`CCT_ST_OVF] |=> status[`CCT_ST_OVF] && count_register == 16'h0000)
    else $error("overflow not flagged or no wrap");
  a_cmp_flag: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE14
    CE_I && state == CCT_COMPARE && count_register == compare_reg_b
    |=> status[`CCT_ST_CMPB])
    else $error("compare match not flagged");
  sequence s_armed;
    CE_I && state == CCT_CAPTURE && trig_edge;
  endsequence
  a_cap_lag: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE13
    (s_armed and (cfg.src == CCT_SRC_F1)) |=> ##1 status[`CCT_ST_CAP])
    else $error("capture flag late");
  a_irq_level: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE5
    status[`CCT_ST_CAP] && mask[`CCT_ST_CAP] |-> EXTERNAL_PIN_IRQ_O && IRQ_O)
    else $error("pin interrupt not raised");
  a_read_count: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE9
    CE_I && RD_I && ADDR_I == `CCT_OFF_COUNT |=> RDATA_O == $past(count_register))
    else $error("count read wrong");
  a_read_capa: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE9
    CE_I && RD_I && ADDR_I == `CCT_OFF_CAPA
    |=> RDATA_O == $past(capture_compare_reg_a))
    else $error("capture read wrong");
  a_rdata_idle: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE9
    CE_I && !RD_I |=> RDATA_O == 16'h0000)
    else $error("read data not cleared after read cycle");

  // a low enable must freeze everything software can see
  a_ce_freeze: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE4
    !CE_I |=> $stable(count_register) && $stable(status) && $stable(RDATA_O))
    else $error("state moved while clock enable low");
  a_stop_idle: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE4
    CE_I && !cfg.count_enable_bit |=> state == CCT_IDLE)
    else $error("state not idle while stopped");

  a_cmpa_flag: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE14
    CE_I && state == CCT_COMPARE && count_register == capture_compare_reg_a
    |=> status[`CCT_ST_CMPA])
    else $error("compare a match not flagged");
  a_no_cmp_cap: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE16
    CE_I && state == CCT_CAPTURE
    |=> !$rose(status[`CCT_ST_CMPA]) && !$rose(status[`CCT_ST_CMPB]))
    else $error("compare flag raised in capture mode");
  a_pend_drop: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE16
    CE_I && state != CCT_CAPTURE |=> !cap_pend)
    else $error("capture pending outside capture mode");
  a_edge_pend: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE13
    s_armed |=> cap_pend)
    else $error("accepted edge not held for next tick");
  a_edge_none: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE10
    cfg.edge_sel == 2'h3 |-> !trig_edge)
    else $error("edge seen with no edge selected");
  a_filt_hold: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE11
    CE_I && !filt_tick |=> $stable(filt_level))
    else $error("filter output moved between samples");
  a_ovf_top: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE6
    CE_I && count_register != 16'hffff |=> !$rose(status[`CCT_ST_OVF]))
    else $error("overflow flag without wrap");

  sequence s_slow_half;
    CE_I && SLOW_OSC_I && slow_cnt == 7'h3f;
  endsequence
  a_slow_div: assert property (@(posedge CORE_CLK_I) disable iff (RST_I) // RULE12
    s_slow_half |=> $rose(slow_osc_div_tick))
    else $error("slow trigger level did not rise");
endmodule

// [tb/cct_pulse_src.sv]
// Purpose: measurement pulse source that drives the capture input pin
// Assumes: pin is a plain synchronous level with no pull, always driven
// Notes:   level changes only just after a rising edge, so the filter sees whole cycles
`timescale 1ns/1ps
module cct_pulse_src (
  // clock
  input  wire logic clk_i,
  // pin
  output logic      level_o
);
  initial level_o = 1'b0;

  // short holds give glitches, long holds give clean pulses
  // chained calls keep each level for exactly hold cycles (hold at least 1)
  task automatic drive(input logic lvl, input int hold);
    @(posedge clk_i);
    level_o <= lvl;
    repeat (hold - 1) @(posedge clk_i);
  endtask
endmodule

// [tb/cct_timer_tb_top.sv]
// Purpose: self-checking bench for the capture/compare timer
// Assumes: one 100 MHz clock, synchronous active-high reset, CE_I high outside one freeze check
// Notes:   overflow test runs a full 16-bit wrap at f1, the bulk of the run time
`timescale 1ns/1ps
module cct_timer_tb_top
  import cct_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        ce = 1'b1;
  logic        fast = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] rdata;
  logic        pin;
  logic        pin_irq;
  logic        irq;
  int          cyc = 0;
  int          fail_count = 0;
  int          checks_done = 0;

  always #5 clk = ~clk;

  cct_timer u_dut (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(bus_wr), .RD_I(bus_rd), .RDATA_O(rdata), .CAPTURE_INPUT_PIN_I(pin),
    .FAST_INTERNAL_OSC_I(fast), .SLOW_OSC_I(slow), .EXTERNAL_PIN_IRQ_O(pin_irq), .IRQ_O(irq));

  cct_pulse_src u_src (.clk_i(clk), .level_o(pin));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // oscillator ticks: fast every 4 cycles, slow every 2; also the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    fast <= (cyc[1:0] == 2'h0);
    slow <= cyc[0];
    if (cyc == 80000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // always a whole word, never split into bytes
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic t_reset();
    logic [15:0] d;
    for (int a = 0; a < 16; a++) begin
      reg_rd(a[3:0], d);
      chk("reset read", d, 16'h0000);
    end
    $display("test reset done");
  endtask

  task automatic t_sources();
    logic [15:0] d0;
    logic [15:0] d1;
    int          ticks [4] = '{64, 8, 2, 16};
    for (int s = 0; s < 4; s++) begin
      reg_wr(4'h3, 16'(s << 1));
      reg_wr(4'h3, 16'(s << 1) | 16'h0001);
      wait_n(4);
      reg_rd(4'h0, d0);
      wait_n(62);
      reg_rd(4'h0, d1);
      chk("ticks per 64 cycles", d1 - d0, 16'(ticks[s]));
    end
    // f1 counting, then 20 frozen edges: only three ticks land between the reads
    reg_wr(4'h3, 16'h0001);
    reg_rd(4'h0, d0);
    @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    reg_rd(4'h0, d1);
    chk("count frozen by enable", d1 - d0, 16'h0003);
    reg_wr(4'h3, 16'h0000);
    reg_rd(4'h0, d0);
    chk("count after stop", d0, 16'h0000);
    $display("test sources done");
  endtask

  task automatic t_edges();
    logic [15:0] d;
    logic [15:0] c0;
    logic [1:0]  hit [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
    reg_wr(4'h6, 16'h0001);
    for (int e = 0; e < 4; e++) begin
      reg_wr(4'h3, 16'(e << 3) | 16'h0001);
      wait_n(8);
      reg_wr(4'h5, 16'h000f);
      reg_rd(4'h0, c0);
      u_src.drive(1'b1, 8);
      #1;
      chk("pin irq after rise", 16'(pin_irq), 16'(hit[e][0]));
      reg_rd(4'h1, d);
      if (e == 0) chk("capture near edge", 16'(d > c0 && d - c0 < 16'h000d), 16'h0001);
      reg_wr(4'h5, 16'h0001);
      u_src.drive(1'b0, 8);
      #1;
      chk("pin irq after fall", 16'(pin_irq), 16'(hit[e][1]));
    end
    // capture mode: both data registers refuse software writes
    reg_rd(4'h1, c0);
    reg_wr(4'h1, ~c0);
    reg_wr(4'h0, 16'hffff);
    reg_rd(4'h1, d);
    chk("capture after write", d, c0);
    reg_rd(4'h0, d);
    chk("count kept running", 16'(d > c0 && d < 16'h1000), 16'h0001);
    $display("test edges done");
  endtask

  task automatic t_filter();
    logic [15:0] d;
    int          wid [4] = '{2, 4, 20, 130};
    logic [15:0] fsel [4] = '{16'h0000, 16'h0000, 16'h0002, 16'h0002};
    reg_wr(4'h3, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      reg_wr(4'h4, fsel[i]);
      reg_wr(4'h5, 16'h000f);
      u_src.drive(1'b1, wid[i]);
      u_src.drive(1'b0, 120);
      reg_rd(4'h5, d);
      chk("filtered capture", d & 16'h0001, 16'(i % 2));
    end
    // trigger from slow oscillator: rising level every 256 cycles here
    reg_wr(4'h4, 16'h0000);
    reg_wr(4'h3, 16'h0081);
    reg_wr(4'h5, 16'h000f);
    // second clear drops a false edge from the trigger switch (set wins the first)
    reg_wr(4'h5, 16'h000f);
    wait_n(600);
    reg_rd(4'h5, d);
    chk("slow trigger capture", d & 16'h0001, 16'h0001);
    $display("test filter done");
  endtask

  task automatic t_overflow();
    logic [15:0] d;
    reg_wr(4'h3, 16'h0000);
    reg_wr(4'h6, 16'h0002);
    reg_wr(4'h5, 16'h000f);
    reg_wr(4'h3, 16'h0001);
    wait_n(65000);
    chk("irq before wrap", 16'(irq), 16'h0000);
    wait_n(560);
    chk("irq after wrap", 16'(irq), 16'h0001);
    reg_rd(4'h0, d);
    chk("count wrapped", 16'(d < 16'h0100), 16'h0001);
    $display("test overflow done");
  endtask

  task automatic t_compare();
    logic [15:0] d;
    reg_wr(4'h3, 16'h0000);
    reg_wr(4'h4, 16'h0008);
    reg_wr(4'h1, 16'h0030);
    reg_wr(4'h2, 16'h0050);
    reg_rd(4'h2, d);
    chk("compare b readback", d, 16'h0050);
    reg_wr(4'h6, 16'h0000);
    reg_wr(4'h5, 16'h000f);
    reg_wr(4'h3, 16'h0001);
    wait_n(64);
    reg_rd(4'h5, d);
    chk("status first match", d, 16'h0004);
    chk("masked irq", 16'(irq), 16'h0000);
    wait_n(40);
    reg_wr(4'h6, 16'h0008);
    wait_n(1);
    chk("second match irq", 16'(irq), 16'h0001);
    reg_wr(4'h3, 16'h0000);
    reg_wr(4'h5, 16'h000f);
    wait_n(1);
    chk("irq after clear", 16'(irq), 16'h0000);
    $display("test compare done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_sources();
    t_edges();
    t_filter();
    t_overflow();
    t_compare();
    test_done();
  end
endmodule
